// ---- design/bsu_pkg.sv ----
// bsu_pkg: constants and carrier types for the bit shuffling unit
package bsu_pkg;

    // datapath width and register index width
    localparam int unsigned DATA_W = 128;
    localparam int unsigned REG_IDX_W = 6;
    // constant word shift distance in bits
    localparam int unsigned WORD_SHIFT = 64;
    // result latency in core clock cycles
    localparam int unsigned RESULT_LATENCY = 1;

    // instruction field positions
    localparam int unsigned OPC_LSB = 24;
    localparam int unsigned FLAG6_LSB = 18;
    localparam int unsigned FLAG4_LSB = 20;
    localparam int unsigned IMM_LSB = 12;
    localparam int unsigned REG3_LSB = 12;
    localparam int unsigned REG2_LSB = 6;
    localparam int unsigned REG1_LSB = 0;
    localparam int unsigned SIZE_LSB = 22;
    localparam int unsigned SIMD_BIT = 21;
    localparam int unsigned DIR_BIT = 20;
    localparam int unsigned ORM_BIT = 20;
    localparam int unsigned HIGH_BIT = 19;

    // opcodes, values arbitrary
    localparam logic [7:0] OPC_DUAL_ASR_IMM = 8'h41;
    localparam logic [7:0] OPC_HALF_INTERLEAVE = 8'h42;
    localparam logic [7:0] OPC_DEINTERLEAVE = 8'h43;
    localparam logic [7:0] OPC_WORD_SHIFT = 8'h44;
    localparam logic [7:0] OPC_LANE_DUPLICATE = 8'h45;
    localparam logic [7:0] OPC_REVERSE_BITS = 8'h46;
    localparam logic [7:0] OPC_REVERSE_BITS_IMM = 8'h47;

    // size flag codes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_DBYTE = 2'h1;
    localparam logic [1:0] SZ_QBYTE = 2'h2;
    localparam logic [1:0] SZ_OBYTE = 2'h3;

    // reserved flag masks, 6-bit field is bits 23:18, 4-bit is 23:20
    localparam logic [3:0] RSV_ASR_IMM = 4'h1;
    localparam logic [5:0] RSV_INTERLEAVE = 6'h0d;
    localparam logic [5:0] RSV_WORD_SHIFT = 6'h3b;
    localparam logic [5:0] RSV_DUPLICATE = 6'h0f;
    localparam logic [5:0] RSV_REVERSE = 6'h03;

    // axi4-lite register map
    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OPCNT = 8'h04;
    localparam logic [7:0] ADDR_BADCNT = 8'h08;
    localparam logic [7:0] ADDR_LASTBAD = 8'h0c;
    localparam int unsigned CTRL_ORM_EN_BIT = 0;
    localparam logic CTRL_ORM_EN_RESET = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // operation issued by the pipeline
    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [DATA_W-1:0] src_b;
        logic [DATA_W-1:0] src_c;
        logic [DATA_W-1:0] dest_old;
    } bsu_issue_type;

    // result and register write ports back to the pipeline
    typedef struct packed {
        logic valid;
        logic illegal;
        logic wr0_en;
        logic [REG_IDX_W-1:0] wr0_addr;
        logic [DATA_W-1:0] wr0_data;
        logic wr1_en;
        logic [REG_IDX_W-1:0] wr1_addr;
        logic [DATA_W-1:0] wr1_data;
    } bsu_result_type;

    // whole module state
    typedef struct packed {
        bsu_result_type result;
        logic aw_got;
        logic [AXI_ADDR_W-1:0] awaddr_q;
        logic w_got;
        logic [31:0] wdata_q;
        logic [3:0] wstrb_q;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic orm_en;
        logic [31:0] opcnt;
        logic [31:0] badcnt;
        logic [31:0] lastbad;
    } bsu_state_type;

endpackage : bsu_pkg

// ---- design/bsu_shuffle.sv ----
// bsu_shuffle: bit shuffling datapath with an axi4-lite control slave
//
// How it works
// - arithmetic shift immediate, shifted-out bits to pair
// - immediate amounts truncated to lane index bits
// - shift immediate fields: opcode flags imm src dest
// - flags 23:22 size, flag 21 selects simd
// - interleave chosen halves of two sources
// - flag 19 picks lower or upper half
// - interleave chunk width follows size flags
// - deinterleave is exact inverse of interleave
// - three register field layout, reserved flags zero
// - word shift moves exactly 64 bits
// - word shift: third field zero, flag 20 direction
// - duplicate lowest chunk into every chunk
// - reverse bits, shift by size-1-amount
// - or-merge with old destination into pair
// - bit reverse ignores simd flag
// - or-merge form optional, software may disable
// - register amount truncated to lane index bits
// - register reverse: amount in 17:12, flag 20
// - immediate reverse: imm 19:12, flags 23:20
// - every result one cycle after issue
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module bsu_shuffle
    import bsu_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pipeline side
    input wire bsu_issue_type issue,
    output var bsu_result_type result,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [AXI_ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [AXI_ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    // lane width in bits from the size flags
    function automatic int lane_width(input logic [1:0] sz);
        int w;
        unique case (sz)
            SZ_BYTE: w = 8;
            SZ_DBYTE: w = 16;
            SZ_QBYTE: w = 32;
            SZ_OBYTE: w = 64;
        endcase
        return w;
    endfunction : lane_width

    // arithmetic right shift per lane, or the bits it pushes out
    function automatic logic [DATA_W-1:0] lane_asr(
        input logic [DATA_W-1:0] a,
        input logic [1:0] sz,
        input logic simd,
        input logic [7:0] amt,
        input logic lost
    );
        logic [DATA_W-1:0] r;
        int w;
        int n;
        int base;
        int pos;
        r = '0;
        w = lane_width(sz);
        n = int'(amt) & (w - 1);
        for (int i = 0; i < DATA_W; i++) begin
            base = (i / w) * w;
            pos = i - base;
            // without simd only the lowest lane is worked
            if (simd || base == 0) begin
                if (lost) begin
                    r[i] = (pos < n) ? a[i] : 1'b0;
                end else if (pos + n < w) begin
                    r[i] = a[base + pos + n];
                end else begin
                    r[i] = a[base + w - 1];
                end
            end
        end
        return r;
    endfunction : lane_asr

    // interleave one half of each source, third source on odd chunks
    function automatic logic [DATA_W-1:0] lane_mix(
        input logic [DATA_W-1:0] b,
        input logic [DATA_W-1:0] c,
        input logic [1:0] sz,
        input logic high
    );
        logic [DATA_W-1:0] r;
        int w;
        int half;
        int chunk;
        int src;
        int pos;
        r = '0;
        w = lane_width(sz);
        half = (DATA_W / w) / 2;
        for (int i = 0; i < DATA_W; i++) begin
            chunk = i / w;
            pos = i % w;
            src = (high ? half : 0) + chunk / 2;
            // even slot from second source, odd slot from third
            r[i] = (chunk % 2 == 1) ? c[src * w + pos] :
                b[src * w + pos];
        end
        return r;
    endfunction : lane_mix

    // undo the interleave: even chunks low half, odd chunks high half
    function automatic logic [DATA_W-1:0] lane_expand(
        input logic [DATA_W-1:0] b,
        input logic [DATA_W-1:0] c,
        input logic [1:0] sz,
        input logic high
    );
        logic [DATA_W-1:0] r;
        logic [DATA_W-1:0] x;
        int w;
        int half;
        int chunk;
        int src;
        int pos;
        r = '0;
        x = high ? c : b;
        w = lane_width(sz);
        half = (DATA_W / w) / 2;
        for (int i = 0; i < DATA_W; i++) begin
            chunk = i / w;
            pos = i % w;
            src = (chunk < half) ? 2 * chunk : 2 * (chunk - half) + 1;
            r[i] = x[src * w + pos];
        end
        return r;
    endfunction : lane_expand

    // copy the lowest lane into every lane
    function automatic logic [DATA_W-1:0] lane_dup(
        input logic [DATA_W-1:0] b,
        input logic [1:0] sz
    );
        logic [DATA_W-1:0] r;
        int w;
        w = lane_width(sz);
        for (int i = 0; i < DATA_W; i++) begin
            r[i] = b[i % w];
        end
        return r;
    endfunction : lane_dup

    // reverse the low lane then shift right by size-1-amount
    function automatic logic [DATA_W-1:0] rev_bits(
        input logic [DATA_W-1:0] b,
        input logic [1:0] sz,
        input logic [7:0] amt
    );
        logic [DATA_W-1:0] r;
        int w;
        int m;
        r = '0;
        w = lane_width(sz);
        m = int'(amt) & (w - 1);
        // low lane only, simd flag not consulted
        for (int i = 0; i < DATA_W; i++) begin
            if (i <= m) begin
                r[i] = b[m - i];
            end
        end
        return r;
    endfunction : rev_bits

    // register offsets that answer
    function automatic logic reg_known(input logic [AXI_ADDR_W-1:0] a);
        return a == ADDR_CTRL || a == ADDR_OPCNT || a == ADDR_BADCNT ||
            a == ADDR_LASTBAD;
    endfunction : reg_known

    // instruction fields
    logic [7:0] opc; // opcode
    logic [5:0] flags6; // three register form flags
    logic [3:0] flags4; // immediate form flags
    logic [7:0] immediate_amount; // shift or reverse immediate
    logic [5:0] reg3_field; // third register number
    logic [5:0] dest; // destination register number
    logic [1:0] size_sel; // lane size code
    logic simd; // simd flag
    logic dir_right; // word shift direction
    logic orm; // or-merge option
    logic high; // half selection

    // field decode
    assign opc = issue.instr[OPC_LSB +: 8];
    assign flags6 = issue.instr[FLAG6_LSB +: 6];
    assign flags4 = issue.instr[FLAG4_LSB +: 4];
    assign immediate_amount = issue.instr[IMM_LSB +: 8];
    assign reg3_field = issue.instr[REG3_LSB +: 6];
    assign dest = issue.instr[REG1_LSB +: 6];
    assign size_sel = issue.instr[SIZE_LSB +: 2];
    assign simd = issue.instr[SIMD_BIT];
    assign dir_right = issue.instr[DIR_BIT];
    assign orm = issue.instr[ORM_BIT];
    assign high = issue.instr[HIGH_BIT];

    // state and its next value
    bsu_state_type s;
    bsu_state_type next_s;
    logic bad_now; // issued operation will be refused
    logic [31:0] ctrl_word; // control register read view
    logic do_write; // write committed this cycle
    logic inc_op; // legal op completes
    logic inc_bad; // illegal op completes

    // handshake outputs straight from state
    assign awready = !s.aw_got;
    assign wready = !s.w_got;
    assign arready = !s.rvalid;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign result = s.result;
    assign ctrl_word = {31'h0, s.orm_en};

    // next state: datapath result, counters and bus slave
    always_comb begin
        next_s = s;
        bad_now = 1'b0;
        // result stands one cycle only
        next_s.result = '0;
        if (issue.valid) begin
            next_s.result.valid = 1'b1;
            next_s.result.wr0_addr = dest;
            next_s.result.wr1_addr = dest + 6'h01;
            case (opc)
                OPC_DUAL_ASR_IMM: begin
                    bad_now = |(flags4 & RSV_ASR_IMM);
                    next_s.result.wr0_data = lane_asr(issue.src_b, size_sel,
                        simd, immediate_amount, 1'b0);
                    next_s.result.wr1_data = lane_asr(issue.src_b, size_sel,
                        simd, immediate_amount, 1'b1);
                    next_s.result.wr1_en = 1'b1;
                end
                OPC_HALF_INTERLEAVE: begin
                    bad_now = |(flags6 & RSV_INTERLEAVE);
                    next_s.result.wr0_data = lane_mix(issue.src_b,
                        issue.src_c, size_sel, high);
                end
                OPC_DEINTERLEAVE: begin
                    bad_now = |(flags6 & RSV_INTERLEAVE);
                    next_s.result.wr0_data = lane_expand(issue.src_b,
                        issue.src_c, size_sel, high);
                end
                OPC_WORD_SHIFT: begin
                    bad_now = |(flags6 & RSV_WORD_SHIFT) ||
                        reg3_field != 6'h00;
                    next_s.result.wr0_data = dir_right ?
                        issue.src_b >> WORD_SHIFT :
                        issue.src_b << WORD_SHIFT;
                end
                OPC_LANE_DUPLICATE: begin
                    bad_now = |(flags6 & RSV_DUPLICATE) ||
                        reg3_field != 6'h00;
                    next_s.result.wr0_data = lane_dup(issue.src_b, size_sel);
                end
                OPC_REVERSE_BITS: begin
                    // amount register value, zero when r0 is named
                    bad_now = |(flags6 & RSV_REVERSE) ||
                        (orm && !s.orm_en);
                    next_s.result.wr0_data = rev_bits(issue.src_b, size_sel,
                        issue.src_c[7:0]);
                    next_s.result.wr1_en = orm;
                end
                OPC_REVERSE_BITS_IMM: begin
                    bad_now = orm && !s.orm_en;
                    next_s.result.wr0_data = rev_bits(issue.src_b, size_sel,
                        immediate_amount);
                    next_s.result.wr1_en = orm;
                end
                default: begin
                    bad_now = 1'b1;
                end
            endcase
            // or-merge with the old destination as base pointer
            if (opc == OPC_REVERSE_BITS || opc == OPC_REVERSE_BITS_IMM) begin
                next_s.result.wr1_data = next_s.result.wr0_data |
                    issue.dest_old;
            end
            if (bad_now) begin
                // refused: flag it and write nothing
                next_s.result.illegal = 1'b1;
                next_s.result.wr1_en = 1'b0;
                next_s.result.wr0_data = '0;
                next_s.result.wr1_data = '0;
            end else begin
                next_s.result.wr0_en = 1'b1;
            end
        end
        inc_op = issue.valid && !bad_now;
        inc_bad = issue.valid && bad_now;
        if (inc_bad) begin
            next_s.lastbad = issue.instr;
        end

        // write address and data taken in either order
        if (awvalid && !s.aw_got) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr_q = awaddr;
        end
        if (wvalid && !s.w_got) begin
            next_s.w_got = 1'b1;
            next_s.wdata_q = wdata;
            next_s.wstrb_q = wstrb;
        end
        do_write = s.aw_got && s.w_got && !s.bvalid;
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        // counters: a write clears, but a same-cycle event still counts
        next_s.opcnt = s.opcnt + {31'h0, inc_op};
        next_s.badcnt = s.badcnt + {31'h0, inc_bad};
        if (do_write) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = reg_known(s.awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            if (s.awaddr_q == ADDR_CTRL && s.wstrb_q[0]) begin
                next_s.orm_en = s.wdata_q[CTRL_ORM_EN_BIT];
            end
            if (s.awaddr_q == ADDR_OPCNT) begin
                next_s.opcnt = {31'h0, inc_op};
            end
            if (s.awaddr_q == ADDR_BADCNT) begin
                next_s.badcnt = {31'h0, inc_bad};
            end
        end

        // read: answer one cycle after the address is taken
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                ADDR_CTRL: next_s.rdata = ctrl_word;
                ADDR_OPCNT: next_s.rdata = s.opcnt;
                ADDR_BADCNT: next_s.rdata = s.badcnt;
                ADDR_LASTBAD: next_s.rdata = s.lastbad;
                default: next_s.rdata = 32'h0;
            endcase
        end
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.orm_en <= CTRL_ORM_EN_RESET;
        end else begin
            s <= next_s;
        end
    end

    // every issue answered on the next edge
    latency_one_a: assert property (@(posedge aclk)
        disable iff (!aresetn) issue.valid |=> result.valid)
        else $error("result missing one cycle after issue");

    // pair port always names destination plus one
    pair_dest_a: assert property (@(posedge aclk)
        disable iff (!aresetn) result.wr1_en |->
        result.wr1_addr == result.wr0_addr + 6'h01)
        else $error("pair write address not destination plus one");

    // shift immediate writes both ports
    asr_pair_a: assert property (@(posedge aclk)
        disable iff (!aresetn) issue.valid && opc == OPC_DUAL_ASR_IMM &&
        !bad_now |=> result.wr0_en && result.wr1_en)
        else $error("shift immediate did not write both ports");

    // refused operations write nothing
    illegal_quiet_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        result.illegal |-> !result.wr0_en && !result.wr1_en)
        else $error("refused operation wrote a register");

    // left word shift moves by exactly one word
    word_shift_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        issue.valid && opc == OPC_WORD_SHIFT && !bad_now && !dir_right
        |=> result.wr0_data == ($past(issue.src_b) << 64))
        else $error("word shift result wrong");

    // byte duplicate fills every byte
    lane_dup_a: assert property (@(posedge aclk)
        disable iff (!aresetn) size_sel == SZ_BYTE &&
        issue.valid && opc == OPC_LANE_DUPLICATE && !bad_now
        |=> result.wr0_data == {16{$past(issue.src_b[7:0])}})
        else $error("lane duplicate result wrong");

    // zero amount keeps only bit zero
    rev_zero_a: assert property (@(posedge aclk)
        disable iff (!aresetn) immediate_amount == 8'h00 &&
        issue.valid && opc == OPC_REVERSE_BITS_IMM && !bad_now
        |=> result.wr0_data == {127'h0, $past(issue.src_b[0])})
        else $error("reverse with zero amount wrong");

    // disabled or-merge form is refused
    orm_gate_a: assert property (@(posedge aclk)
        disable iff (!aresetn) issue.valid && !s.orm_en &&
        opc == OPC_REVERSE_BITS && orm |=> result.illegal)
        else $error("disabled or-merge form not refused");

    // merged pair value is result or old destination
    orm_merge_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        issue.valid && opc == OPC_REVERSE_BITS_IMM && orm && !bad_now
        |=> result.wr1_data == (result.wr0_data | $past(issue.dest_old)))
        else $error("or-merge value wrong");

    // write response holds until taken
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");

endmodule : bsu_shuffle

`default_nettype wire

// ---- testbench/bsu_pipe_model.sv ----
// bsu_pipe_model: pipeline partner that issues ops and collects results
`timescale 1ns/10ps
`default_nettype none
module bsu_pipe_model
    import bsu_pkg::*;
(
    // clock
    input wire logic aclk,
    // issue and result
    output var bsu_issue_type issue,
    input wire bsu_result_type result
);
    initial issue = '0;
    // one op: offer for one edge, then scramble idle fields, take result
    task automatic run(input logic [31:0] ins, input logic [127:0] b,
            input logic [127:0] c, input logic [127:0] d,
            output bsu_result_type r);
        bsu_issue_type t;
        t = '{1'b1, ins, b, c, d};
        @(posedge aclk);
        issue <= t;
        t = ~t;
        t.valid = 1'b0;
        @(posedge aclk);
        issue <= t;
        #1 r = result;
    endtask : run
endmodule : bsu_pipe_model
`default_nettype wire

// ---- testbench/bit_shuffle_ops_tb_top.sv ----
// bit_shuffle_ops_tb_top: self-checking bench of the shuffle unit
`timescale 1ns/10ps
`default_nettype none
module bit_shuffle_ops_tb_top;
    import bsu_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    bsu_issue_type issue;
    bsu_result_type result, r;
    int fail_count = 0, comparisons = 0;
    always #10 aclk = ~aclk;
    bsu_shuffle dut (.aclk, .aresetn, .issue, .result, .awvalid, .awready,
        .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
    bsu_pipe_model pipe (.aclk, .issue, .result);
    // compare and count
    task automatic chk(string n, logic [127:0] e, logic [127:0] s);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // result ports against expectation
    task automatic res(logic ill, logic e1, logic [5:0] a, logic [127:0] d0,
            logic [127:0] d1);
        chk("valid", 1, r.valid);
        chk("illegal", ill, r.illegal);
        chk("wr0_en", !ill, r.wr0_en);
        chk("wr1_en", e1, r.wr1_en);
        if (!ill) chk("wr0_addr", a, r.wr0_addr);
        if (!ill) chk("wr0_data", d0, r.wr0_data);
        if (e1) chk("wr1_addr", 6'(a + 6'h01), r.wr1_addr);
        if (e1) chk("wr1_data", d1, r.wr1_data);
    endtask : res
    // axi4-lite write, address and data offered together
    task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        @(posedge aclk);
        awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; wstrb <= 4'hf;
        bready <= 1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        bready <= 0;
        chk("bresp", er, bresp);
    endtask : axw
    // axi4-lite read
    task automatic axr(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        @(posedge aclk);
        arvalid <= 1; araddr <= a; rready <= 1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        rready <= 0;
        chk("rresp", er, rresp);
        chk("rdata", ed, rdata);
    endtask : axr
    // reversal of the low m+1 bits
    function automatic logic [127:0] rev(logic [127:0] b, int m);
        rev = '0;
        for (int i = 0; i <= m; i++) rev[i] = b[m-i];
    endfunction : rev
    // dual shift, amount 0x44 wraps to 4, pair wraps to register 0
    task automatic t_asr();
        pipe.run({OPC_DUAL_ASR_IMM, 4'hc, 8'h44, 6'd2, 6'd63},
            {64'h1234, 64'h8000_0000_0000_00f5}, 0, 0, r);
        res(0, 1, 6'd63, 128'hf800_0000_0000_000f, 128'h5);
        pipe.run({OPC_DUAL_ASR_IMM, 4'hd, 8'h4, 6'd2, 6'd1}, 1, 0, 0, r);
        res(1, 0, 0, 0, 0);
        pipe.run({OPC_DUAL_ASR_IMM, 4'h2, 8'h0b, 6'd2, 6'd4}, {16{8'h96}},
            0, 0, r);
        res(0, 1, 6'd4, {16{8'hf2}}, {16{8'h06}});
        $display("test asr done");
    endtask : t_asr
    // interleave then deinterleave, every size and half
    task automatic t_mix();
        logic [127:0] b, c, m;
        int w;
        b = 128'h0f0e0d0c0b0a09080706050403020100;
        c = 128'hfffefdfcfbfaf9f8f7f6f5f4f3f2f1f0;
        for (int s = 0; s < 4; s++) for (int h = 0; h < 2; h++) begin
            w = 8 << s;
            for (int i = 0; i < 64; i++) begin
                m[2*(i/w)*w+i%w] = b[h*64+i];
                m[(2*(i/w)+1)*w+i%w] = c[h*64+i];
            end
            pipe.run({OPC_HALF_INTERLEAVE, 2'(s), 2'b0, 1'(h), 7'h3, 6'd2,
                6'd1}, b, c, 0, r);
            res(0, 0, 6'd1, m, 0);
            pipe.run({OPC_DEINTERLEAVE, 2'(s), 2'b0, 1'(h), 7'h3, 6'd2,
                6'd1}, h ? 0 : m, h ? m : 0, 0, r);
            res(0, 0, 6'd1, {c[h*64+:64], b[h*64+:64]}, 0);
        end
        $display("test mix done");
    endtask : t_mix
    // word shift both ways, and nonzero third field refused
    task automatic t_misc();
        logic [127:0] b, e;
        b = 128'h0123456789abcdef_fedcba9876543210;
        for (int d = 0; d < 2; d++) begin
            pipe.run({OPC_WORD_SHIFT, 3'b0, 1'(d), 14'h4, 6'd5}, b, 0, 0, r);
            res(0, 0, 6'd5, d ? b >> 64 : b << 64, 0);
        end
        pipe.run({OPC_WORD_SHIFT, 6'h0, 6'd7, 6'd4, 6'd5}, b, 0, 0, r);
        res(1, 0, 0, 0, 0);
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < 128; i++) e[i] = b[i%(8<<s)];
            pipe.run({OPC_LANE_DUPLICATE, 2'(s), 16'h2, 6'd1}, b, 0, 0, r);
            res(0, 0, 6'd1, e, 0);
        end
        $display("test misc done");
    endtask : t_misc
    // bit reverse, register and immediate amount, each with and without merge
    task automatic t_rev();
        pipe.run({OPC_REVERSE_BITS, 4'hf, 2'b0, 6'd3, 6'd2, 6'd1}, 128'h48,
            128'hff47, 128'hff00_0100, r);
        res(0, 1, 6'd1, rev(128'h48, 7),
            rev(128'h48, 7) | 128'hff00_0100);
        pipe.run({OPC_REVERSE_BITS_IMM, 4'h9, 8'h25, 6'd2, 6'd1}, 128'h48,
            0, 128'h40, r);
        res(0, 1, 6'd1, rev(128'h48, 5), rev(128'h48, 5) | 128'h40);
        pipe.run({OPC_REVERSE_BITS_IMM, 4'h0, 8'h0, 6'd2, 6'd1}, 128'h49,
            0, 0, r);
        res(0, 0, 6'd1, 128'h1, 0);
        pipe.run({OPC_REVERSE_BITS, 4'hc, 2'b0, 6'd0, 6'd2, 6'd1}, 128'h48,
            0, 0, r);
        res(0, 0, 6'd1, rev(128'h48, 0), 0);
        $display("test rev done");
    endtask : t_rev
    // control registers, merge disabled, unmapped access
    task automatic t_axi();
        axr(ADDR_OPCNT, 32'h1c, RESP_OKAY);
        axr(ADDR_CTRL, 32'h1, RESP_OKAY);
        axw(ADDR_BADCNT, 32'h0, RESP_OKAY);
        axw(ADDR_CTRL, 32'h0, RESP_OKAY);
        pipe.run({OPC_REVERSE_BITS, 4'hd, 8'h0, 12'h81}, 1, 0, 0, r);
        res(1, 0, 0, 0, 0);
        axr(ADDR_BADCNT, 32'h1, RESP_OKAY);
        axr(ADDR_LASTBAD, {OPC_REVERSE_BITS, 4'hd, 8'h0, 12'h81}, RESP_OKAY);
        axr(8'h10, 32'h0, RESP_SLVERR);
        axw(8'h10, 32'h0, RESP_SLVERR);
        axw(ADDR_CTRL, 32'h1, RESP_OKAY);
        $display("test axi done");
    endtask : t_axi
    // counts, verdict, end of run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_asr();
        t_mix();
        t_misc();
        t_rev();
        t_axi();
        give_verdict();
    end
    // watchdog
    initial begin
        #200us;
        fail_count++;
        give_verdict();
    end
endmodule : bit_shuffle_ops_tb_top
`default_nettype wire
